/* verilog/ddc_pkg.sv */
// Constants and types shared by both ends of the diskette drive link.
package ddc_pkg;
   // ******************************************************************
   // Clock and timing
   // ******************************************************************
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned POWERUP_MS    = 100;
   localparam int unsigned POWERUP_CYC   = POWERUP_MS * 1000 * CLK_MHZ;
   localparam int unsigned SPINUP_MS     = 1000;
   localparam int unsigned SPINUP_CYC    = SPINUP_MS * 1000 * CLK_MHZ;
   localparam int unsigned IDLE_OFF_MS   = 2000;
   localparam int unsigned IDLE_OFF_CYC  = IDLE_OFF_MS * 1000 * CLK_MHZ;
   localparam int unsigned STEP_RATE_MS  = 40;
   localparam int unsigned STEP_RATE_CYC = STEP_RATE_MS * 1000 * CLK_MHZ;
   localparam int unsigned STEP_LOW_US   = 1;
   localparam int unsigned STEP_LOW_CYC  = STEP_LOW_US * CLK_MHZ;
   localparam int unsigned DIR_SETUP_US  = 1;
   localparam int unsigned DIR_SETUP_CYC = DIR_SETUP_US * CLK_MHZ;
   localparam int unsigned PHASE_GAP_US  = 10;
   localparam int unsigned PHASE_GAP_CYC = PHASE_GAP_US * CLK_MHZ;
   localparam int unsigned TMR_W         = 28;
   localparam int unsigned GAP_W         = 11;
   // ******************************************************************
   // Mechanism
   // ******************************************************************
   localparam int unsigned       TRK_W     = 6;
   localparam logic [TRK_W-1:0]  TRACK_MAX = 6'h22;
   localparam logic [TRK_W-1:0]  TRACK_RST = 6'h00;
   localparam logic [5:0]        RECAL_MAX = 6'h3A;
   localparam logic [1:0]        PH_A      = 2'h0;
   // ******************************************************************
   // Drive input sampling layout and idle levels
   // ******************************************************************
   localparam int unsigned SY_SEL   = 0;
   localparam int unsigned SY_MOTOR = 3;
   localparam int unsigned SY_DIR   = 4;
   localparam int unsigned SY_STEP  = 5;
   localparam int unsigned SY_WG    = 6;
   localparam int unsigned SY_WDATA = 7;
   localparam int unsigned SY_STRAP = 8;
   localparam int unsigned SY_CHAIN = 11;
   localparam int unsigned SY_W     = 12;
   localparam logic [SY_W-1:0] SYNC_RST  = 12'hFFF;
   localparam logic [1:0]      HSYNC_RST = 2'h3;
   localparam logic [2:0]      SEL_IDLE  = 3'h7;
   localparam logic            LINE_IDLE = 1'h1;
   // ******************************************************************
   // Controller registers
   // ******************************************************************
   localparam int unsigned ADDR_W     = 12;
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_CMD    = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam int unsigned CTRL_SEL_EN   = 0;
   localparam int unsigned CTRL_ADDR     = 1;
   localparam int unsigned CTRL_MOTOR    = 3;
   localparam int unsigned CTRL_WGATE    = 4;
   localparam int unsigned CTRL_AUTO_OFF = 5;
   localparam int unsigned CMD_CNT       = 0;
   localparam int unsigned CMD_CNT_W     = 6;
   localparam int unsigned CMD_OUT       = 6;
   localparam int unsigned CMD_RECAL     = 7;
   // Controller sequencer states, Gray coded along idle, setup, low, hold and back to idle.
   typedef enum logic [1:0] {
      HS_IDLE  = 2'h0,
      HS_SETUP = 2'h1,
      HS_LOW   = 2'h3,
      HS_HOLD  = 2'h2
   } ddc_hstate_t;
endpackage : ddc_pkg

/* verilog/ddc_if.sv */
// Cable between the controller and the drive, with open-collector lines.
`timescale 1ns/1ns
`default_nettype none
interface ddc_if;
   logic [2:0] sel_n;
   logic       motor_n;
   logic       dir_in_n;
   logic       step_n;
   logic       wgate_n;
   logic       wdata_n;
   logic       trk0_val;
   logic       trk0_oe;
   logic       rd_val;
   logic       rd_oe;
   logic       trk0_n;
   logic       rd_n;
   // Open-collector outputs float high unless the drive pulls them.
   assign trk0_n = trk0_oe ? trk0_val : 1'h1;
   assign rd_n   = rd_oe ? rd_val : 1'h1;
   modport drive (
      input  sel_n, motor_n, dir_in_n, step_n, wgate_n, wdata_n,
      output trk0_val, trk0_oe, rd_val, rd_oe
   );
   modport ctrl (
      output sel_n, motor_n, dir_in_n, step_n, wgate_n, wdata_n,
      input  trk0_n, rd_n
   );
endinterface : ddc_if
`default_nettype wire

/* verilog/ddc_drive.sv */
// Drive end: selection, head load, stepper sequencing and write gating.
// ********************************************************************
// ********************************************************************
`timescale 1ns/1ns
`default_nettype none
module ddc_drive (
   // Clock, reset and clock enable.
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   // Cable to the controller.
   ddc_if.drive                       link,
   // Straps, high while the strap is closed.
   input  wire logic                  address_strap_one,
   input  wire logic                  address_strap_two,
   input  wire logic                  address_strap_three,
   input  wire logic                  chain_mode_strap,
   // Flux pulses from the read amplifier, high for one pulse.
   input  wire logic                  read_flux,
   // Mechanism controls.
   output logic                       head_load,
   output logic                       lamp_on,
   output logic                       motor_run,
   output logic [1:0]                 stepper_phase,
   output logic [ddc_pkg::TRK_W-1:0]  head_track,
   // Read and write channel controls.
   output logic                       read_enable,
   output logic                       write_enable,
   output logic                       write_current
);
   import ddc_pkg::*;

   // *****************************************************************
   // State
   // *****************************************************************
   typedef struct packed {
      logic [SY_W-1:0]  s1;
      logic [SY_W-1:0]  s2;
      logic             step_prev;
      logic             wdata_prev;
      logic             busy;
      logic [GAP_W-1:0] gap;
      logic             dir_out;
      logic [TRK_W-1:0] track;
      logic [1:0]       phase;
      logic             slip;
      logic             head_load;
      logic             lamp;
      logic             motor;
      logic             rd_en;
      logic             wr_en;
      logic             wr_cur;
      logic             trk0_val;
      logic             trk0_oe;
      logic             rd_val;
      logic             rd_oe;
   } ddc_drv_t;

   localparam ddc_drv_t DRV_RST = '{
      s1:       SYNC_RST,
      s2:       SYNC_RST,
      step_prev:  LINE_IDLE,
      wdata_prev: LINE_IDLE,
      track:    TRACK_RST,
      phase:    PH_A,
      default:  '0
   };

   ddc_drv_t r;
   ddc_drv_t n;

   // *****************************************************************
   // Decoding of the synchronised inputs
   // *****************************************************************
   logic [2:0] sel_act;
   logic [2:0] straps;
   logic       chained;
   logic       selected;
   logic       io_en;
   logic       wg_act;
   logic       step_edge;
   logic       wdata_fall;
   logic       at_zero;

   // Select lines are active low; a closed strap lets its line through.
   assign sel_act  = ~r.s2[SY_SEL +: 3];
   assign straps   = r.s2[SY_STRAP +: 3];
   assign selected = |(sel_act & straps);
   // A cut chain strap switches to chained operation.
   assign chained  = ~r.s2[SY_CHAIN];
   // Unchained the lines are always live; chained only when selected.
   assign io_en    = ~chained | selected;
   assign wg_act   = io_en & ~r.s2[SY_WG];
   // Step acts on its trailing edge, low to high, only without write.
   assign step_edge = io_en & r.s2[SY_WG] & r.s2[SY_STEP]
                    & ~r.step_prev;
   // Write data counts on its falling edge while writing is gated on.
   assign wdata_fall = wg_act & ~r.s2[SY_WDATA]
                     & r.wdata_prev;
   assign at_zero   = (r.track == TRACK_RST);

   // *****************************************************************
   // Next state
   // *****************************************************************
   // One process computes the whole next state from the present one.
   always_comb begin
      n = r;
      // Two flip-flops on every cable line and strap.
      n.s1 = {chain_mode_strap, address_strap_three, address_strap_two,
              address_strap_one, link.wdata_n, link.wgate_n,
              link.step_n, link.dir_in_n, link.motor_n,
              link.sel_n};
      n.s2 = r.s1;
      n.step_prev  = r.s2[SY_STEP];
      n.wdata_prev = r.s2[SY_WDATA];

      // Head load and lamp follow the strapped select line.
      n.head_load = selected;
      n.lamp      = selected;
      n.motor     = ~r.s2[SY_MOTOR];

      // Write gate chooses between the read and the write path.
      n.rd_en = io_en & r.s2[SY_WG];
      n.wr_en = wg_act;
      if (wdata_fall) begin
         n.wr_cur = ~r.wr_cur;
      end

      // Stepper: the first increment starts on the edge, the drive
      // makes the second one after a settling gap by itself.
      if (r.busy) begin
         if (r.gap == GAP_W'(PHASE_GAP_CYC - 1)) begin
            n.busy = 1'h0;
            n.gap  = '0;
            if (r.dir_out) begin
               n.phase = r.phase - 2'h1;
               if (at_zero) begin
                  // Carriage rests on its stop; stepper slips a track.
                  n.slip = ~r.slip;
               end else begin
                  n.track = r.track - 6'h01;
               end
            end else begin
               n.phase = r.phase + 2'h1;
               if (r.slip) begin
                  n.slip = 1'h0;
               end else if (r.track != TRACK_MAX) begin
                  n.track = r.track + 6'h01;
               end
            end
         end else begin
            n.gap = r.gap + GAP_W'(1);
         end
      end else if (step_edge) begin
         // Direction is latched on the same edge that starts motion.
         n.dir_out = r.s2[SY_DIR];
         n.busy    = 1'h1;
         n.gap     = '0;
         if (r.s2[SY_DIR]) begin
            n.phase = r.phase - 2'h1;
         end else begin
            n.phase = r.phase + 2'h1;
         end
      end

      // Track zero shows only on the outer track with phase A powered.
      n.trk0_val = 1'h0;
      n.trk0_oe  = io_en & at_zero & (r.phase == PH_A)
                 & ~r.slip;
      // Read pulses pull the read line only while reading is enabled.
      n.rd_val   = 1'h0;
      n.rd_oe    = r.rd_en & read_flux;
   end

   // *****************************************************************
   // Registers
   // *****************************************************************
   // Synchronous reset; a low clock enable freezes every flip-flop.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         r <= DRV_RST;
      end else if (clk_en) begin
         r <= n;
      end
   end

   // *****************************************************************
   // Outputs
   // *****************************************************************
   // All outputs come straight from the state register.
   assign link.trk0_val = r.trk0_val;
   assign link.trk0_oe  = r.trk0_oe;
   assign link.rd_val   = r.rd_val;
   assign link.rd_oe    = r.rd_oe;
   assign head_load     = r.head_load;
   assign lamp_on       = r.lamp;
   assign motor_run     = r.motor;
   assign stepper_phase = r.phase;
   assign head_track    = r.track;
   assign read_enable   = r.rd_en;
   assign write_enable  = r.wr_en;
   assign write_current = r.wr_cur;
endmodule : ddc_drive
`default_nettype wire

/* verilog/ddc_host.sv */
// Controller end: APB registers, power-up and motor timing, seek sequencer.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ddc_host #(
   parameter int unsigned POWERUP_CYC   = ddc_pkg::POWERUP_CYC,
   parameter int unsigned SPINUP_CYC    = ddc_pkg::SPINUP_CYC,
   parameter int unsigned IDLE_OFF_CYC  = ddc_pkg::IDLE_OFF_CYC,
   parameter int unsigned STEP_RATE_CYC = ddc_pkg::STEP_RATE_CYC
) (
   // Clock, reset and clock enable.
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   clk_en,
   // APB slave.
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ddc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Cable to the drive.
   ddc_if.ctrl                         link,
   // Formatter side: encoded write flux in, read pulses out.
   input  wire logic                   wr_flux,
   output logic                        rd_pulse
);
   import ddc_pkg::*;

   // *****************************************************************
   // State
   // *****************************************************************
   typedef struct packed {
      logic [1:0]           s1;
      logic [1:0]           s2;
      logic                 rd_prev;
      logic                 sel_en;
      logic [1:0]           addr;
      logic                 motor;
      logic                 wgate;
      logic                 auto_off;
      ddc_hstate_t          state;
      logic [TMR_W-1:0]     tmr;
      logic [TMR_W-1:0]     pwr_cnt;
      logic [TMR_W-1:0]     spin_cnt;
      logic [TMR_W-1:0]     idle_cnt;
      logic                 pwr_ok;
      logic                 spun;
      logic [CMD_CNT_W-1:0] steps;
      logic                 recal;
      logic                 recal_fail;
      logic [2:0]           sel_n;
      logic                 motor_n;
      logic                 dir_in_n;
      logic                 step_n;
      logic                 wgate_n;
      logic                 wdata_n;
      logic                 rd_pulse;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
   } ddc_host_t;

   localparam ddc_host_t HOST_RST = '{
      s1: HSYNC_RST, s2: HSYNC_RST, rd_prev: LINE_IDLE,
      state: HS_IDLE, sel_n: SEL_IDLE, motor_n: LINE_IDLE,
      dir_in_n: LINE_IDLE, step_n: LINE_IDLE, wgate_n: LINE_IDLE,
      wdata_n: LINE_IDLE, pready: 1'h1, default: '0
   };

   ddc_host_t   r;
   ddc_host_t   n;
   logic        trk0;
   logic        busy;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;

   // Register read views; bit order follows the field positions.
   assign trk0        = ~r.s2[0];
   assign busy        = (r.state != HS_IDLE);
   assign ctrl_word   = {26'h0, r.auto_off, r.wgate, r.motor, r.addr,
                         r.sel_en};
   assign status_word = {27'h0, r.recal_fail, r.pwr_ok, r.spun, trk0,
                         busy};

   // *****************************************************************
   // Next state
   // *****************************************************************
   always_comb begin
      n = r;
      // Drive outputs pass two flip-flops before use.
      n.s1       = {link.rd_n, link.trk0_n};
      n.s2       = r.s1;
      n.rd_prev  = r.s2[1];
      n.rd_pulse = r.rd_prev & ~r.s2[1] & r.wgate_n;

      // Power-up delay gates seek commands and the write gate.
      if (!r.pwr_ok) begin
         n.pwr_cnt = r.pwr_cnt + TMR_W'(1);
         if (r.pwr_cnt == TMR_W'(POWERUP_CYC - 1)) begin
            n.pwr_ok = 1'h1;
         end
      end
      // Spin-up delay after the motor is requested.
      if (!r.motor) begin
         n.spin_cnt = '0;
         n.spun     = 1'h0;
      end else if (!r.spun) begin
         n.spin_cnt = r.spin_cnt + TMR_W'(1);
         if (r.spin_cnt == TMR_W'(SPINUP_CYC - 1)) begin
            n.spun = 1'h1;
         end
      end
      // Motor drops after an idle spell when auto-off is set.
      if (!r.motor || !r.auto_off || busy || !r.wgate_n) begin
         n.idle_cnt = '0;
      end else if (r.idle_cnt == TMR_W'(IDLE_OFF_CYC - 1)) begin
         n.idle_cnt = '0;
         n.motor    = 1'h0;
      end else begin
         n.idle_cnt = r.idle_cnt + TMR_W'(1);
      end

      // Seek sequencer: direction setup, step low, step high and wait.
      case (r.state)
         HS_IDLE: begin
         end
         HS_SETUP: begin
            if (r.recal && trk0) begin
               n.state = HS_IDLE;
            end else if (r.tmr == TMR_W'(DIR_SETUP_CYC - 1)) begin
               n.tmr    = '0;
               n.step_n = 1'h0;
               n.state  = HS_LOW;
            end else begin
               n.tmr = r.tmr + TMR_W'(1);
            end
         end
         HS_LOW: begin
            if (r.tmr == TMR_W'(STEP_LOW_CYC - 1)) begin
               n.tmr    = '0;
               n.step_n = 1'h1;
               n.steps  = r.steps - 6'h01;
               n.state  = HS_HOLD;
            end else begin
               n.tmr = r.tmr + TMR_W'(1);
            end
         end
         HS_HOLD: begin
            if (r.tmr == TMR_W'(STEP_RATE_CYC - 1)) begin
               n.tmr = '0;
               if (r.steps == '0) begin
                  n.recal_fail = r.recal & ~trk0;
                  n.state      = HS_IDLE;
               end else begin
                  n.state = HS_SETUP;
               end
            end else begin
               n.tmr = r.tmr + TMR_W'(1);
            end
         end
         default: begin
            n.state = HS_IDLE;
         end
      endcase

      // APB setup phase prepares read data and the error answer.
      if (psel && !penable) begin
         n.prdata  = 32'h0;
         n.pslverr = 1'h0;
         case (paddr)
            REG_CTRL:   n.prdata = ctrl_word;
            REG_CMD:    n.prdata = 32'h0;
            REG_STATUS: n.prdata = status_word;
            default:    n.pslverr = 1'h1;
         endcase
      end
      // APB access phase: writes take effect here.
      if (psel && penable && pwrite && !r.pslverr) begin
         if (paddr == REG_CTRL) begin
            n.sel_en   = pwdata[CTRL_SEL_EN];
            n.addr     = pwdata[CTRL_ADDR +: 2];
            n.motor    = pwdata[CTRL_MOTOR];
            n.wgate    = pwdata[CTRL_WGATE];
            n.auto_off = pwdata[CTRL_AUTO_OFF];
         end else if (paddr == REG_CMD && !busy && r.pwr_ok
                      && (pwdata[CMD_RECAL]
                          || pwdata[CMD_CNT +: CMD_CNT_W] != '0)) begin
            n.recal      = pwdata[CMD_RECAL];
            n.recal_fail = 1'h0;
            n.steps      = pwdata[CMD_RECAL] ? RECAL_MAX
                         : pwdata[CMD_CNT +: CMD_CNT_W];
            // Line high steps outward; recalibration always goes out.
            n.dir_in_n   = pwdata[CMD_OUT] | pwdata[CMD_RECAL];
            n.tmr        = '0;
            n.state      = HS_SETUP;
         end
      end

      // Cable drive: select forced during a seek, write gate qualified.
      n.sel_n   = ~((r.sel_en | busy) ? (3'h1 << r.addr) : 3'h0);
      n.motor_n = ~r.motor;
      n.wgate_n = ~(r.wgate & r.pwr_ok & r.spun & r.sel_en
                    & ~busy);
      n.wdata_n = ~(~r.wgate_n & wr_flux);
   end

   // *****************************************************************
   // Registers
   // *****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         r <= HOST_RST;
      end else if (clk_en) begin
         r <= n;
      end
   end

   // Outputs come straight from the state register.
   assign prdata        = r.prdata;
   assign pready        = r.pready;
   assign pslverr       = r.pslverr;
   assign rd_pulse      = r.rd_pulse;
   assign link.sel_n    = r.sel_n;
   assign link.motor_n  = r.motor_n;
   assign link.dir_in_n = r.dir_in_n;
   assign link.step_n   = r.step_n;
   assign link.wgate_n  = r.wgate_n;
   assign link.wdata_n  = r.wdata_n;
endmodule : ddc_host
`default_nettype wire

/* bench/ddc_monitor.sv */
// Assertion monitor watching the cable between controller and drive.
`timescale 1ns/1ns
`default_nettype none
module ddc_monitor import ddc_pkg::*; (
   // Clock and reset.
   input wire logic       ref_clk,
   input wire logic       reset_n,
   // Cable lines.
   input wire logic [2:0] sel_n,
   input wire logic       dir_in_n,
   input wire logic       step_n,
   input wire logic       wgate_n,
   input wire logic       wdata_n,
   input wire logic       trk0_oe,
   input wire logic       rd_oe,
   input wire logic       trk0_n,
   // Drive pins.
   input wire logic       chain_mode_strap,
   input wire logic       head_load,
   input wire logic       read_enable,
   input wire logic       write_enable,
   input wire logic       write_current,
   input wire logic [1:0] stepper_phase,
   input wire logic [5:0] head_track
);
   // ******************************************************************
   // Cable and mechanism checks
   // ******************************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   trk0_place_a: assert property (
      !trk0_n |-> $past(head_track) == 6'h00 && $past(stepper_phase) == PH_A)
      else $error("track zero shown away from track zero phase A");
   one_track_a: assert property ($changed(head_track) |->
      head_track == $past(head_track) + 6'h01 ||
      head_track + 6'h01 == $past(head_track))
      else $error("head moved more than one track");
   step_out_a: assert property (
      $changed(head_track) && head_track < $past(head_track) |-> dir_in_n)
      else $error("outward move without outward direction");
   step_in_a: assert property (
      $changed(head_track) && head_track > $past(head_track) |-> !dir_in_n)
      else $error("inward move without inward direction");
   half_step_a: assert property (
      $rose(step_n) && wgate_n && head_load |-> ##[2:6] $changed(stepper_phase))
      else $error("step edge gave no stepper increment");
   gate_read_a: assert property (!wgate_n [*4] |-> !read_enable)
      else $error("read path enabled while writing");
   flux_flip_a: assert property (
      $fell(wdata_n) && write_enable |-> ##[2:4] $changed(write_current))
      else $error("write data fall did not reverse current");
   idle_unload_a: assert property (sel_n == SEL_IDLE [*4] |-> !head_load)
      else $error("head loaded with no select line active");
   chain_quiet_a: assert property (
      (!chain_mode_strap && sel_n == SEL_IDLE) [*5] |-> !trk0_oe && !rd_oe)
      else $error("unselected chained drive drives the cable");
endmodule : ddc_monitor
`default_nettype wire

/* bench/testbench.sv */
// Bench joining controller and drive, with a track model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import ddc_pkg::*;
   logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, wr_flux = 0, rd_pulse, read_flux = 0;
   logic s1 = 1, s2 = 1, s3 = 1, chain = 1, wc_q = 0, clk_en = 1, motor_run;
   logic head_load, lamp_on, read_enable, write_enable, write_current;
   logic [1:0] stepper_phase;
   logic [5:0] head_track;
   int comparisons = 0, miscompares = 0, trk = 0, wtog = 0, rcnt = 0, n;
   ddc_if ddc_if_inst ();
   ddc_host #(.POWERUP_CYC(50), .SPINUP_CYC(100), .IDLE_OFF_CYC(300),
      .STEP_RATE_CYC(1400)) ddc_host_inst (.ref_clk, .reset_n,
      .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .link(ddc_if_inst), .wr_flux, .rd_pulse);
   ddc_drive ddc_drive_inst (.ref_clk, .reset_n, .clk_en,
      .link(ddc_if_inst), .address_strap_one(s1), .address_strap_two(s2),
      .address_strap_three(s3), .chain_mode_strap(chain), .read_flux,
      .head_load, .lamp_on, .motor_run, .stepper_phase, .head_track,
      .read_enable, .write_enable, .write_current);
   ddc_monitor ddc_monitor_inst (.ref_clk, .reset_n,
      .sel_n(ddc_if_inst.sel_n), .dir_in_n(ddc_if_inst.dir_in_n),
      .step_n(ddc_if_inst.step_n), .wgate_n(ddc_if_inst.wgate_n),
      .wdata_n(ddc_if_inst.wdata_n), .trk0_oe(ddc_if_inst.trk0_oe),
      .rd_oe(ddc_if_inst.rd_oe), .trk0_n(ddc_if_inst.trk0_n),
      .chain_mode_strap(chain), .head_load, .read_enable, .write_enable,
      .write_current, .stepper_phase, .head_track);
   // Clock and the counters of write reversals and read pulses.
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (write_current !== wc_q) wtog++;
      if (rd_pulse === 1'b1) rcnt++;
      wc_q <= write_current;
   end
   task automatic chk(input string nm, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer; an idle edge first keeps transfers apart.
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk) penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // Polls the busy flag, then checks the head against the model.
   task automatic idle;
      rd[0] = 1'b1;
      for (int i = 0; i < 20000 && rd[0] !== 1'b0; i++) apb(0, REG_STATUS, 0);
      chk("track", trk, head_track);
   endtask : idle
   task automatic pulses(input int k, input logic w);
      repeat (6) @(posedge ref_clk);
      repeat (k) begin
         @(posedge ref_clk) {wr_flux, read_flux} <= {w, !w};
         @(posedge ref_clk) {wr_flux, read_flux} <= 2'h0;
         repeat (3) @(posedge ref_clk);
      end
      repeat (8) @(posedge ref_clk);
   endtask : pulses
   task automatic complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   initial begin
      #800000;
      miscompares++;
      complete_run;
   end
   initial begin
      n = $urandom(32'hF273);
      repeat (2) @(posedge ref_clk);
      reset_n <= 1;
      repeat (60) @(posedge ref_clk);
      apb(0, 12'hFF0, 0);
      chk("slverr", 1, err);
      apb(1, REG_CTRL, 32'h9);
      repeat (120) @(posedge ref_clk);
      chk("head_load", 1, head_load);
      chk("lamp", 1, lamp_on);
      chk("motor", 1, motor_run);
      clk_en <= 0;
      apb(1, REG_CTRL, 32'h0);
      clk_en <= 1;
      repeat (8) @(posedge ref_clk);
      chk("frozen", 1, head_load);
      for (int k = 0; k < 3; k++) begin
         n = $urandom_range(4, 1);
         trk += n;
         apb(1, REG_CMD, n);
         idle;
      end
      n = $urandom_range(trk - 1, 1);
      trk -= n;
      apb(1, REG_CMD, n | 32'h40);
      idle;
      trk = 0;
      apb(1, REG_CMD, 32'h80);
      idle;
      chk("trk0 line", 0, ddc_if_inst.trk0_n);
      for (int k = 1; k < 3; k++) begin
         apb(1, REG_CMD, 32'h41);
         idle;
         chk("trk0 slip", k & 1, ddc_if_inst.trk0_n);
      end
      n = $urandom_range(9, 2);
      wtog = 0;
      apb(1, REG_CTRL, 32'h19);
      pulses(n, 1);
      chk("reversals", n, wtog);
      apb(1, REG_CTRL, 32'h9);
      rcnt = 0;
      pulses(n, 0);
      chk("read pulses", n, rcnt);
      {chain, s1, s3} <= 3'h0;
      rcnt = 0;
      apb(1, REG_CTRL, 32'h8);
      pulses(2, 0);
      chk("quiet read", 0, rcnt);
      apb(1, REG_CTRL, 32'h9);
      repeat (8) @(posedge ref_clk);
      chk("other drive", 0, head_load);
      apb(1, REG_CTRL, 32'hB);
      repeat (8) @(posedge ref_clk);
      chk("own drive", 1, head_load);
      apb(1, REG_CTRL, 32'h2B);
      repeat (320) @(posedge ref_clk);
      apb(0, REG_CTRL, 0);
      chk("auto off", 32'h23, rd);
      chk("motor off", 0, motor_run);
      complete_run;
   end
endmodule : testbench
`default_nettype wire
